// ---- src/uie_pkg.sv ----
// constants and layouts shared by the usb interrupt enable block
package uie_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int NFLAG = 4;
  localparam int EP_W = 3;
  localparam int SYNC_W = 2;
  localparam int SYNC_ATTACH = 0;
  localparam int SYNC_WAKE = 1;

  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_CLEAR = 12'h008;

  localparam logic [DATA_W-1:0] EN_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] EN_MASK = 32'h0000_810f;
  localparam logic [DATA_W-1:0] FLAG_MASK = 32'h0000_000f;

  localparam int BIT_BUS = 0;
  localparam int BIT_TXN = 1;
  localparam int BIT_ATTACH = 2;
  localparam int BIT_WAKE = 3;
  localparam int BIT_WAKE_FN = 8;
  localparam int BIT_IN_NAK = 15;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- src/uie_sync_change.sv ----
// three-flop synchroniser that pulses once per settled change of a pin
`timescale 1ns/100ps
`default_nettype none
module uie_sync_change
(
  input wire logic aclk, // block clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [uie_pkg::SYNC_W-1:0] pin_in, // asynchronous pin levels
  output logic [uie_pkg::SYNC_W-1:0] change_p // one-cycle pulse per settled change
);
  typedef struct packed {
    logic [uie_pkg::SYNC_W-1:0] s1;
    logic [uie_pkg::SYNC_W-1:0] s2;
    logic [uie_pkg::SYNC_W-1:0] s3;
    logic [uie_pkg::SYNC_W-1:0] level;
    logic [uie_pkg::SYNC_W-1:0] chg;
  } uie_sync_s;

  uie_sync_s s_q;
  uie_sync_s s_d;

  // s1 feeds only s2; a change counts once s2 and s3 agree
  always_comb
  begin
    s_d = s_q;
    s_d.s1 = pin_in;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.chg = ~(s_q.s2 ^ s_q.s3) & (s_q.s3 ^ s_q.level);
    s_d.level = (~(s_q.s2 ^ s_q.s3) & s_q.s3) | ((s_q.s2 ^ s_q.s3) & s_q.level);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign change_p = s_q.chg;
endmodule
`default_nettype wire

// ---- src/uie_top.sv ----
// usb interrupt enable register with event flags, axi4-lite slave and irq
`timescale 1ns/100ps
`default_nettype none
module uie_top
(
  input wire logic aclk, // block clock, 10 mhz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [uie_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [uie_pkg::DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [uie_pkg::STRB_W-1:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [uie_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [uie_pkg::DATA_W-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic bus_event, // suspend or resume seen, one-cycle pulse
  input wire logic txn_event, // token or handshake event, one-cycle pulse
  input wire logic in_nak, // nak given to an in token, one-cycle pulse
  input wire logic [uie_pkg::EP_W-1:0] in_nak_ep, // endpoint of that nak
  input wire logic attach_pin, // asynchronous attach level
  input wire logic wake_pin, // asynchronous bus activity level
  output logic irq, // interrupt request, level, active high
  output logic wake_function_en, // wake-up function enabled
  output logic in_nak_report_en, // in-nak reporting enabled
  output logic endpoint_state_wr, // write nak into endpoint state, pulse
  output logic [uie_pkg::EP_W-1:0] endpoint_state_ep // endpoint to update
);
  typedef struct packed {
    logic [uie_pkg::DATA_W-1:0] en;
    logic [uie_pkg::NFLAG-1:0] flags;
    logic irq;
    logic aw_full;
    logic [uie_pkg::ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [uie_pkg::DATA_W-1:0] w_data;
    logic [uie_pkg::STRB_W-1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [uie_pkg::DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic nak_wr;
    logic [uie_pkg::EP_W-1:0] nak_ep;
  } uie_state_s;

  uie_state_s s_q;
  uie_state_s s_d;
  logic [uie_pkg::SYNC_W-1:0] pin_change;
  logic [uie_pkg::NFLAG-1:0] set_ev;
  logic [uie_pkg::NFLAG-1:0] clr_ev;
  logic [uie_pkg::DATA_W-1:0] wmerged;
  logic write_go;

  uie_sync_change u_sync
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in({wake_pin, attach_pin}),
    .change_p(pin_change)
  );

  // word-aligned match; low two address bits are ignored
  function automatic logic hit(input logic [uie_pkg::ADDR_W-1:0] a, input logic [uie_pkg::ADDR_W-1:0] off);
    hit = (a[uie_pkg::ADDR_W-1:2] == off[uie_pkg::ADDR_W-1:2]);
  endfunction

  function automatic logic [uie_pkg::DATA_W-1:0] merge(input logic [uie_pkg::DATA_W-1:0] old,
    input logic [uie_pkg::DATA_W-1:0] wd, input logic [uie_pkg::STRB_W-1:0] strb);
    merge = old;
    for (int i = 0; i < uie_pkg::STRB_W; i++)
    begin
      if (strb[i])
        merge[i*8 +: 8] = wd[i*8 +: 8];
    end
  endfunction

  assign s_axi_awready = !s_q.aw_full;
  assign s_axi_wready = !s_q.w_full;
  assign s_axi_arready = !s_q.rvalid;
  assign write_go = s_q.aw_full && s_q.w_full && !s_q.bvalid;

  always_comb
  begin
    s_d = s_q;
    set_ev = '0;
    clr_ev = '0;
    wmerged = '0;
    s_d.nak_wr = 1'b0;
    if (s_axi_awvalid && !s_q.aw_full)
    begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_full)
    begin
      s_d.w_full = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;
    // a write acts only once both halves are held and the last answer is gone
    if (write_go)
    begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = uie_pkg::RESP_OKAY;
      if (hit(s_q.aw_addr, uie_pkg::OFF_IRQ_EN))
        s_d.en = merge(s_q.en, s_q.w_data, s_q.w_strb) & uie_pkg::EN_MASK;
      else if (hit(s_q.aw_addr, uie_pkg::OFF_CLEAR))
      begin
        wmerged = merge('0, s_q.w_data, s_q.w_strb);
        clr_ev = wmerged[uie_pkg::NFLAG-1:0];
      end
      else if (!hit(s_q.aw_addr, uie_pkg::OFF_FLAGS))
        s_d.bresp = uie_pkg::RESP_SLVERR;
    end
    if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;
    if (s_axi_arvalid && !s_q.rvalid)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = uie_pkg::RESP_OKAY;
      s_d.rdata = '0;
      if (hit(s_axi_araddr, uie_pkg::OFF_IRQ_EN))
        s_d.rdata = s_q.en & uie_pkg::EN_MASK;
      else if (hit(s_axi_araddr, uie_pkg::OFF_FLAGS))
        s_d.rdata = {{(uie_pkg::DATA_W-uie_pkg::NFLAG){1'b0}}, s_q.flags};
      else if (!hit(s_axi_araddr, uie_pkg::OFF_CLEAR))
        s_d.rresp = uie_pkg::RESP_SLVERR;
    end
    set_ev[uie_pkg::BIT_BUS] = bus_event;
    set_ev[uie_pkg::BIT_ATTACH] = pin_change[uie_pkg::SYNC_ATTACH];
    // wake activity is ignored entirely while the wake function is off
    set_ev[uie_pkg::BIT_WAKE] = pin_change[uie_pkg::SYNC_WAKE] && s_q.en[uie_pkg::BIT_WAKE_FN];
    set_ev[uie_pkg::BIT_TXN] = txn_event;
    if (in_nak && s_q.en[uie_pkg::BIT_IN_NAK])
    begin
      s_d.nak_wr = 1'b1;
      s_d.nak_ep = in_nak_ep;
      set_ev[uie_pkg::BIT_TXN] = 1'b1;
    end
    // a set arriving with its clear wins, so no event is lost
    s_d.flags = (s_q.flags & ~clr_ev) | set_ev;
    s_d.irq = 1'b0;
    s_d.irq = s_d.irq | (s_d.flags[uie_pkg::BIT_BUS] & s_d.en[uie_pkg::BIT_BUS]);
    s_d.irq = s_d.irq | (s_d.flags[uie_pkg::BIT_TXN] & s_d.en[uie_pkg::BIT_TXN]);
    s_d.irq = s_d.irq | (s_d.flags[uie_pkg::BIT_ATTACH] & s_d.en[uie_pkg::BIT_ATTACH]);
    s_d.irq = s_d.irq | (s_d.flags[uie_pkg::BIT_WAKE] & s_d.en[uie_pkg::BIT_WAKE]);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.en <= uie_pkg::EN_RESET;
    end
    else
      s_q <= s_d;
  end

  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign irq = s_q.irq;
  assign wake_function_en = s_q.en[uie_pkg::BIT_WAKE_FN];
  assign in_nak_report_en = s_q.en[uie_pkg::BIT_IN_NAK];
  assign endpoint_state_wr = s_q.nak_wr;
  assign endpoint_state_ep = s_q.nak_ep;

  property p_reset_enables;
    @(posedge aclk) $rose(aresetn) |-> (s_q.en == '0) && !s_q.irq;
  endproperty
  a_reset_enables: assert property (p_reset_enables) else $error("enables not zero after reset");

  property p_bus_gate;
    @(posedge aclk) disable iff (!aresetn)
      (s_q.flags[uie_pkg::BIT_BUS] && s_q.en[uie_pkg::BIT_BUS]) |-> s_q.irq;
  endproperty
  a_bus_gate: assert property (p_bus_gate) else $error("enabled bus flag without irq");

  property p_txn_gate;
    @(posedge aclk) disable iff (!aresetn)
      (txn_event && s_q.en[uie_pkg::BIT_TXN] && !write_go) |=> s_q.flags[uie_pkg::BIT_TXN] && s_q.irq;
  endproperty
  a_txn_gate: assert property (p_txn_gate) else $error("transaction event did not raise irq");

  property p_attach_gate;
    @(posedge aclk) disable iff (!aresetn)
      (s_q.flags[uie_pkg::BIT_ATTACH] && s_q.en[uie_pkg::BIT_ATTACH]) |-> s_q.irq;
  endproperty
  a_attach_gate: assert property (p_attach_gate) else $error("enabled attach flag without irq");

  property p_wake_gate;
    @(posedge aclk) disable iff (!aresetn)
      (s_q.flags[uie_pkg::BIT_WAKE] && s_q.en[uie_pkg::BIT_WAKE]) |-> s_q.irq;
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("enabled wake flag without irq");

  property p_wake_fn_off;
    @(posedge aclk) disable iff (!aresetn)
      !s_q.en[uie_pkg::BIT_WAKE_FN] |=> !$rose(s_q.flags[uie_pkg::BIT_WAKE]);
  endproperty
  a_wake_fn_off: assert property (p_wake_fn_off) else $error("wake flag set while wake function off");

  property p_nak_off;
    @(posedge aclk) disable iff (!aresetn)
      !s_q.en[uie_pkg::BIT_IN_NAK] |=> !s_q.nak_wr;
  endproperty
  a_nak_off: assert property (p_nak_off) else $error("nak recorded while reporting off");

  property p_nak_on;
    @(posedge aclk) disable iff (!aresetn)
      (in_nak && s_q.en[uie_pkg::BIT_IN_NAK]) |=>
        s_q.nak_wr && s_q.flags[uie_pkg::BIT_TXN] && (s_q.nak_ep == $past(in_nak_ep));
  endproperty
  a_nak_on: assert property (p_nak_on) else $error("nak not recorded or flagged");

  property p_irq_cause;
    @(posedge aclk) disable iff (!aresetn)
      s_q.irq |-> (s_q.flags & s_q.en[uie_pkg::NFLAG-1:0]) != '0;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without an enabled flag");

  property p_flag_sticky;
    @(posedge aclk) disable iff (!aresetn)
      ##1 ((s_q.flags & $past(s_q.flags) & ~$past(clr_ev)) == ($past(s_q.flags) & ~$past(clr_ev)));
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without a clear");

  property p_reserved_zero;
    @(posedge aclk) disable iff (!aresetn)
      (s_q.en & ~uie_pkg::EN_MASK) == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved enable bit set");

  property p_reset_outputs;
    @(posedge aclk) !aresetn |=> !s_q.irq && !wake_function_en && !in_nak_report_en && !endpoint_state_wr
      && !s_axi_bvalid && !s_axi_rvalid && s_axi_awready && s_axi_wready && s_axi_arready;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not idle after reset");

  property p_set_wins;
    @(posedge aclk) disable iff (!aresetn)
      (set_ev != '0) |=> (s_q.flags & $past(set_ev)) == $past(set_ev);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event did not set its flag");

  property p_clear_drops;
    @(posedge aclk) disable iff (!aresetn)
      (clr_ev != '0) |=> (s_q.flags & $past(clr_ev) & ~$past(set_ev)) == '0;
  endproperty
  a_clear_drops: assert property (p_clear_drops) else $error("cleared flag still set");

  property p_bvalid_hold;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped before bready");

  property p_rvalid_hold;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped before rready");

  property p_write_answer;
    @(posedge aclk) disable iff (!aresetn)
      write_go |=> s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered");

  property p_read_answer;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");

  property p_nak_source;
    @(posedge aclk) disable iff (!aresetn)
      endpoint_state_wr |-> $past(in_nak) && $past(in_nak_report_en);
  endproperty
  a_nak_source: assert property (p_nak_source) else $error("endpoint state written without enabled nak");

  property p_flags_read;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, uie_pkg::OFF_FLAGS)) |=>
        s_axi_rdata == {{(uie_pkg::DATA_W-uie_pkg::NFLAG){1'b0}}, $past(s_q.flags)};
  endproperty
  a_flags_read: assert property (p_flags_read) else $error("flag read returned wrong value");

  property p_en_read;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, uie_pkg::OFF_IRQ_EN)) |=>
        (s_axi_rdata == $past(s_q.en)) && ((s_axi_rdata & ~uie_pkg::EN_MASK) == '0);
  endproperty
  a_en_read: assert property (p_en_read) else $error("enable read returned wrong value");

  property p_en_write;
    @(posedge aclk) disable iff (!aresetn)
      (write_go && hit(s_q.aw_addr, uie_pkg::OFF_IRQ_EN) && (s_q.w_strb == '1)) |=>
        s_q.en == ($past(s_q.w_data) & uie_pkg::EN_MASK);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write not stored masked");

  property p_unmapped_write;
    @(posedge aclk) disable iff (!aresetn)
      (write_go && !hit(s_q.aw_addr, uie_pkg::OFF_IRQ_EN) && !hit(s_q.aw_addr, uie_pkg::OFF_CLEAR)
        && !hit(s_q.aw_addr, uie_pkg::OFF_FLAGS)) |=> s_axi_bresp == uie_pkg::RESP_SLVERR;
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write not refused");

  property p_flags_ro;
    @(posedge aclk) disable iff (!aresetn)
      (write_go && hit(s_q.aw_addr, uie_pkg::OFF_FLAGS)) |=> (s_axi_bresp == uie_pkg::RESP_OKAY)
        && ((s_q.flags & ~$past(set_ev)) == ($past(s_q.flags) & ~$past(set_ev)));
  endproperty
  a_flags_ro: assert property (p_flags_ro) else $error("flag register write changed flags");

  property p_irq_off;
    @(posedge aclk) disable iff (!aresetn)
      (s_q.en[uie_pkg::NFLAG-1:0] == '0) |-> !s_q.irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with all enables off");

  property p_wake_fn_on;
    @(posedge aclk) disable iff (!aresetn)
      (pin_change[uie_pkg::SYNC_WAKE] && s_q.en[uie_pkg::BIT_WAKE_FN]) |=> s_q.flags[uie_pkg::BIT_WAKE];
  endproperty
  a_wake_fn_on: assert property (p_wake_fn_on) else $error("wake change not flagged");

  property p_attach_flag;
    @(posedge aclk) disable iff (!aresetn)
      pin_change[uie_pkg::SYNC_ATTACH] |=> s_q.flags[uie_pkg::BIT_ATTACH];
  endproperty
  a_attach_flag: assert property (p_attach_flag) else $error("attach change not flagged");

  property p_bus_flag;
    @(posedge aclk) disable iff (!aresetn)
      bus_event |=> s_q.flags[uie_pkg::BIT_BUS];
  endproperty
  a_bus_flag: assert property (p_bus_flag) else $error("bus event not flagged");
endmodule
`default_nettype wire

// ---- testbench/uie_host_model.sv ----
// usb bus side stand-in that raises bus events, pin changes and in-nak replies
`timescale 1ns/100ps
`default_nettype none
module uie_host_model
(
  input wire logic aclk, // block clock
  output logic bus_event, // suspend or resume pulse
  output logic txn_event, // transaction pulse
  output logic in_nak, // nak to in token pulse
  output logic [uie_pkg::EP_W-1:0] in_nak_ep, // endpoint of the nak
  output logic attach_pin, // attach level
  output logic wake_pin // bus activity level
);
  initial
  begin
    bus_event = 1'b0;
    txn_event = 1'b0;
    in_nak = 1'b0;
    in_nak_ep = 3'h0;
    attach_pin = 1'b0;
    wake_pin = 1'b0;
  end
  // kind 0 bus, 1 transaction, 2 attach, 3 wake, other in-nak
  task automatic send(input int kind, input logic [uie_pkg::EP_W-1:0] ep);
    @(posedge aclk);
    case (kind)
      0: bus_event <= 1'b1;
      1: txn_event <= 1'b1;
      2: attach_pin <= ~attach_pin;
      3: wake_pin <= ~wake_pin;
      default:
      begin
        in_nak <= 1'b1;
        in_nak_ep <= ep;
      end
    endcase
    @(posedge aclk);
    bus_event <= 1'b0;
    txn_event <= 1'b0;
    in_nak <= 1'b0;
    // endpoint is not held after the pulse, so show a changed value
    in_nak_ep <= ~ep;
  endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// register and event tests of the usb interrupt enable block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
  logic awready, wready, arready, irq, wfn_en, nak_en, ep_wr;
  logic bus_event, txn_event, in_nak, attach_pin, wake_pin;
  logic [uie_pkg::ADDR_W-1:0] awaddr, araddr;
  logic [uie_pkg::DATA_W-1:0] wdata, rdata, d;
  logic [1:0] bresp, rresp;
  logic [uie_pkg::STRB_W-1:0] wstrb;
  logic [uie_pkg::EP_W-1:0] nak_ep_in, ep_out, nak_ep;
  int error_cnt = 0;
  int compares = 0;
  int nak_cnt = 0;
  uie_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus_event(bus_event),
    .txn_event(txn_event), .in_nak(in_nak), .in_nak_ep(nak_ep_in), .attach_pin(attach_pin),
    .wake_pin(wake_pin), .irq(irq), .wake_function_en(wfn_en), .in_nak_report_en(nak_en),
    .endpoint_state_wr(ep_wr), .endpoint_state_ep(ep_out));
  uie_host_model host (.aclk(aclk), .bus_event(bus_event), .txn_event(txn_event), .in_nak(in_nak),
    .in_nak_ep(nak_ep_in), .attach_pin(attach_pin), .wake_pin(wake_pin));
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    if (ep_wr === 1'b1)
    begin
      nak_cnt <= nak_cnt + 1;
      nak_ep <= ep_out;
    end
  end
  task automatic test_done();
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    error_cnt++;
    $display("ERROR %0t: bus answer missing", $time);
    test_done();
  endtask
  // ready is sampled mid-cycle; it only moves on edges, so it is what the next edge sees
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s = 4'hf,
    input logic [1:0] er = uie_pkg::RESP_OKAY);
    bit ta, tw, tb;
    logic [1:0] b;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      b = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb)
      begin
        bready <= 1'b0;
        chk({30'h0, b}, {30'h0, er});
        return;
      end
    end
    hang();
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = uie_pkg::RESP_OKAY);
    bit ta, tr;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr)
      begin
        rready <= 1'b0;
        chk(d, e);
        chk({30'h0, r}, {30'h0, er});
        return;
      end
    end
    hang();
  endtask
  task automatic tick();
    repeat (3) @(posedge aclk);
    #1;
  endtask
  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(uie_pkg::OFF_IRQ_EN, 32'h0000_0000);
    chk({29'h0, irq, wfn_en, nak_en}, 32'h0);
    wr(uie_pkg::OFF_IRQ_EN, 32'hffff_ffff);
    rd(uie_pkg::OFF_IRQ_EN, 32'h0000_810f);
    chk({30'h0, wfn_en, nak_en}, 32'h3);
    rd(12'h100, 32'h0000_0000, uie_pkg::RESP_SLVERR);
    wr(12'h100, 32'h0000_0001, 4'hf, uie_pkg::RESP_SLVERR);
    rd(uie_pkg::OFF_CLEAR, 32'h0000_0000);
    wr(uie_pkg::OFF_IRQ_EN, 32'h0000_0000, 4'h2);
    rd(12'h003, 32'h0000_000f);
    chk({30'h0, wfn_en, nak_en}, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(uie_pkg::OFF_IRQ_EN, (32'h1 << i) | 32'h0000_0100);
      host.send(i, 3'h0);
      repeat (8) @(posedge aclk);
      rd(uie_pkg::OFF_FLAGS, 32'h1 << i);
      chk({31'h0, irq}, 32'h1);
      wr(uie_pkg::OFF_IRQ_EN, 32'h0000_0100);
      tick();
      chk({31'h0, irq}, 32'h0);
      wr(uie_pkg::OFF_CLEAR, 32'h0000_0000);
      wr(uie_pkg::OFF_FLAGS, 32'hffff_ffff);
      rd(uie_pkg::OFF_FLAGS, 32'h1 << i);
      wr(uie_pkg::OFF_CLEAR, 32'h1 << i);
      rd(uie_pkg::OFF_FLAGS, 32'h0000_0000);
    end
    wr(uie_pkg::OFF_IRQ_EN, 32'h0000_000a);
    host.send(3, 3'h0);
    host.send(4, 3'h5);
    repeat (8) @(posedge aclk);
    rd(uie_pkg::OFF_FLAGS, 32'h0000_0000);
    chk(nak_cnt, 32'h0);
    wr(uie_pkg::OFF_IRQ_EN, 32'h0000_8002);
    host.send(4, 3'h5);
    tick();
    chk(nak_cnt, 32'h1);
    chk({29'h0, nak_ep}, 32'h5);
    chk({31'h0, irq}, 32'h1);
    rd(uie_pkg::OFF_FLAGS, 32'h0000_0002);
    test_done();
  end
endmodule
`default_nettype wire
